// ===== src/dioe_top.sv
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - force-terminal overrides both sources to 01
// - force-terminal off restores programmed sources
// - override change while driving stops motor first
// - force/ready functions assignable to all five selectors
// - ready-hold keeps output stage active without run
// - without ready-hold, run does normal start
// - estop halts switching through hardware path
// - estop reserves terminals 1, 3 and 4
// - terminal 4 reset clears estop trip
// - terminal 3 normally-closed stop trips output
// - open or miswired terminal 3 also trips
// - only terminal 4 clears trip; keypad cannot
// - estop stops switching, outputs stay energized
// - estop only active with enable switch on
module dioe_top
  import dioe_pkg::*;
(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic [NUM_TERM-1:0] terminal_in,
  input  wire logic                estop_enable_switch,
  input  wire logic                keypad_reset,
  output logic                     gate_enable,
  output logic                     outputs_energized,
  output logic                     estop_trip,
  output logic      [1:0]          freq_source_select,
  output logic      [1:0]          run_source_select,
  output logic                     irq
);
  import dioe_pkg::*;

  typedef enum logic [2:0] {
    DIOE_IDLE,
    DIOE_READY,
    DIOE_START,
    DIOE_RUN,
    DIOE_STOP,
    DIOE_TRIP
  } dioe_state_type;

  localparam int unsigned MW = $clog2(START_CYC > STOP_CYC ? START_CYC : STOP_CYC) + 1;

  dioe_func_if fn ();

  logic [NUM_TERM-1:0]   term_level;
  logic [1:0]            sw_meta;
  logic [1:0]            kp_meta;
  logic                  sw_sync;
  logic [4:0]            ctrl;
  logic [NUM_TERM*8-1:0] selectors;
  logic [INT_WIDTH-1:0]  int_stat;
  logic [INT_WIDTH-1:0]  int_mask;
  logic [INT_WIDTH-1:0]  int_event;
  logic                  trip;
  logic                  ovr_applied;
  logic                  ovr_pending;
  logic                  run_cmd;
  dioe_state_type        state;
  dioe_state_type        next_state;
  logic [MW-1:0]         timer;
  logic                  timer_done;
  logic                  wr_en;
  logic [31:0]           next_prdata;
  logic                  addr_ok;
  logic                  energized;

  // motor is being driven, brought up or ramped down
  function automatic logic is_driving(input dioe_state_type s);
    return (s == DIOE_RUN) || (s == DIOE_START) || (s == DIOE_STOP);
  endfunction : is_driving

  dioe_debounce #(
    .WIDTH (NUM_TERM),
    .COUNT (DEBOUNCE_CYC)
  ) u_debounce (
    .pclk    (pclk),
    .presetn (presetn),
    .raw     (terminal_in),
    .level   (term_level)
  );

  // the switch is a board strap; a plain double flop is enough
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sw_meta <= 2'h0;
      kp_meta <= 2'h0;
    end
    else
    begin
      sw_meta <= {sw_meta[0], estop_enable_switch};
      kp_meta <= {kp_meta[0], keypad_reset};
    end
  end
  assign sw_sync = sw_meta[1];

  dioe_func_map u_map (
    .level     (term_level),
    .selectors (selectors),
    .estop_en  (sw_sync),
    .fn        (fn.src)
  );

  assign pready  = 1'b1;
  assign wr_en   = psel & penable & pwrite;
  always_comb
  begin
    unique case (paddr)
      ADDR_CTRL, ADDR_SEL_LO, ADDR_SEL_HI,
      ADDR_STATUS, ADDR_INT_STAT, ADDR_INT_MASK: addr_ok = 1'b1;
      default:                                   addr_ok = 1'b0;
    endcase
  end
  assign pslverr = psel & penable & ~addr_ok;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl      <= CTRL_RESET;
      selectors <= SEL_RESET;
      int_mask  <= '0;
    end
    else if (wr_en)
    begin
      unique case (paddr)
        ADDR_CTRL:     ctrl <= pwdata[4:0];
        ADDR_SEL_LO:   selectors[31:0] <= pwdata;
        ADDR_SEL_HI:   selectors[39:32] <= pwdata[7:0];
        ADDR_INT_MASK: int_mask <= pwdata[INT_WIDTH-1:0];
        default:       ;
      endcase
    end
  end

  // sticky events; a new event beats a same-cycle write-one clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      int_stat <= '0;
    else
      int_stat <= (int_stat & ~((wr_en && paddr == ADDR_INT_STAT) ?
                                pwdata[INT_WIDTH-1:0] : '0)) | int_event;
  end
  assign irq = |(int_stat & int_mask);

  always_comb
  begin
    next_prdata = 32'h0000_0000;
    unique case (paddr)
      ADDR_CTRL:     next_prdata[4:0] = ctrl;
      ADDR_SEL_LO:   next_prdata = selectors[31:0];
      ADDR_SEL_HI:   next_prdata[7:0] = selectors[39:32];
      ADDR_INT_STAT: next_prdata[INT_WIDTH-1:0] = int_stat;
      ADDR_INT_MASK: next_prdata[INT_WIDTH-1:0] = int_mask;
      ADDR_STATUS:
      begin
        next_prdata[ST_FREQ_LSB +: 2]        = freq_source_select;
        next_prdata[ST_RUN_LSB +: 2]         = run_source_select;
        next_prdata[ST_OVERRIDE]             = ovr_applied;
        next_prdata[ST_READY]                = fn.ready_hold;
        next_prdata[ST_TRIP]                 = trip;
        next_prdata[ST_GATE]                 = gate_enable;
        next_prdata[ST_ENERGIZED]            = outputs_energized;
        next_prdata[ST_ESTOP_EN]             = sw_sync;
        next_prdata[ST_TERM_LSB +: NUM_TERM] = term_level;
        next_prdata[ST_CODE_LSB +: 8]        = trip ? ESTOP_TRIP_CODE : 8'h00;
      end
      default:       ;
    endcase
  end

  // read data is registered in the setup cycle so it stands in the access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= next_prdata;
  end

  // trip latch: only the terminal-4 reset clears it, the keypad is ignored
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      trip <= 1'b0;
    else if (!fn.estop_level)
      trip <= 1'b1;
    else if (fn.trip_reset && !kp_meta[1])
      trip <= 1'b0;
    else if (fn.trip_reset)
      trip <= 1'b0;
  end
  assign estop_trip = trip;

  // override only switches when the motor is not being driven
  assign ovr_pending = fn.force_terminal != ovr_applied;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ovr_applied <= 1'b0;
    else if (ovr_pending && !is_driving(state))
      ovr_applied <= fn.force_terminal;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      freq_source_select <= 2'h0;
      run_source_select  <= 2'h0;
    end
    else if (ovr_applied)
    begin
      freq_source_select <= SRC_TERMINALS;
      run_source_select  <= SRC_TERMINALS;
    end
    else
    begin
      freq_source_select <= ctrl[CTRL_FREQ_LSB +: 2];
      run_source_select  <= ctrl[CTRL_RUN_LSB +: 2];
    end
  end

  assign run_cmd = (ovr_applied || ctrl[CTRL_RUN_LSB +: 2] == SRC_TERMINALS) ?
                   fn.run_fwd : ctrl[CTRL_RUN_SW];
  assign timer_done = timer == '0;

  always_comb
  begin
    next_state = state;
    unique case (state)
      DIOE_IDLE:
      begin
        if (fn.ready_hold) next_state = DIOE_READY;
        else if (run_cmd && !ovr_pending) next_state = DIOE_START;
      end
      DIOE_READY:
      begin
        if (run_cmd && !ovr_pending) next_state = DIOE_RUN;
        else if (!fn.ready_hold) next_state = DIOE_IDLE;
      end
      DIOE_START:
      begin
        if (ovr_pending || !run_cmd) next_state = DIOE_STOP;
        else if (timer_done) next_state = DIOE_RUN;
      end
      DIOE_RUN:
      begin
        if (ovr_pending || !run_cmd) next_state = DIOE_STOP;
      end
      DIOE_STOP:
      begin
        if (timer_done) next_state = DIOE_IDLE;
      end
      DIOE_TRIP:
      begin
        if (!trip) next_state = DIOE_IDLE;
      end
    endcase
    if (trip) next_state = DIOE_TRIP;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= DIOE_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer <= '0;
    end
    else if (next_state == DIOE_START && state != DIOE_START)
    begin
      timer <= MW'(START_CYC - 1);
    end
    else if (next_state == DIOE_STOP && state != DIOE_STOP)
    begin
      timer <= MW'(STOP_CYC - 1);
    end
    else if (!timer_done)
    begin
      timer <= timer - MW'(1);
    end
  end

  // the stop contact gates switching directly, independent of software state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gate_enable <= 1'b0;
    end
    else
    begin
      gate_enable <= fn.estop_level && !trip &&
                     (next_state inside {DIOE_READY, DIOE_RUN, DIOE_STOP});
    end
  end

  // power stays on the stage during a trip; only switching stops
  assign energized = next_state inside {DIOE_READY, DIOE_START, DIOE_RUN, DIOE_STOP};
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      outputs_energized <= 1'b0;
    else if (next_state != DIOE_TRIP)
      outputs_energized <= energized;
  end

  assign int_event[INT_TRIP]     = !fn.estop_level && !trip;
  assign int_event[INT_OVERRIDE] = ovr_pending && !is_driving(state);
  assign int_event[INT_STARTED]  = state == DIOE_START && next_state == DIOE_RUN;

endmodule : dioe_top
`default_nettype wire

// ===== src/dioe_pkg.sv
package dioe_pkg;
  localparam int unsigned CLK_MHZ           = 125;
  localparam int unsigned NUM_TERM          = 5;
  localparam int unsigned DEBOUNCE_NS       = 10000;
  localparam int unsigned DEBOUNCE_CYC      = DEBOUNCE_NS * CLK_MHZ / 1000;
  localparam int unsigned START_NS          = 20000;
  localparam int unsigned START_CYC         = (START_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned STOP_NS           = 20000;
  localparam int unsigned STOP_CYC          = (STOP_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0]  ADDR_CTRL         = 8'h00;
  localparam logic [7:0]  ADDR_SEL_LO       = 8'h04;
  localparam logic [7:0]  ADDR_SEL_HI       = 8'h08;
  localparam logic [7:0]  ADDR_STATUS       = 8'h0c;
  localparam logic [7:0]  ADDR_INT_STAT     = 8'h10;
  localparam logic [7:0]  ADDR_INT_MASK     = 8'h14;
  localparam int unsigned CTRL_FREQ_LSB     = 0;
  localparam int unsigned CTRL_RUN_LSB      = 2;
  localparam int unsigned CTRL_RUN_SW       = 4;
  localparam logic [4:0]  CTRL_RESET        = 5'h00;
  localparam logic [1:0]  SRC_TERMINALS     = 2'h1;
  localparam logic [7:0]  FUNC_RUN_FWD      = 8'h00;
  localparam logic [7:0]  FUNC_RUN_REV      = 8'h01;
  localparam logic [7:0]  FUNC_TRIP_RESET   = 8'h12;
  localparam logic [7:0]  FUNC_FORCE_TERM   = 8'h33;
  localparam logic [7:0]  FUNC_READY_HOLD   = 8'h34;
  localparam logic [7:0]  FUNC_NONE         = 8'hff;
  localparam logic [39:0] SEL_RESET         = {FUNC_TRIP_RESET, FUNC_READY_HOLD,
                                               FUNC_FORCE_TERM, FUNC_RUN_REV,
                                               FUNC_RUN_FWD};
  localparam logic [7:0]  ESTOP_TRIP_CODE   = 8'h37;
  localparam int unsigned ST_FREQ_LSB       = 0;
  localparam int unsigned ST_RUN_LSB        = 2;
  localparam int unsigned ST_OVERRIDE       = 4;
  localparam int unsigned ST_READY          = 5;
  localparam int unsigned ST_TRIP           = 6;
  localparam int unsigned ST_GATE           = 7;
  localparam int unsigned ST_ENERGIZED      = 8;
  localparam int unsigned ST_ESTOP_EN       = 9;
  localparam int unsigned ST_TERM_LSB       = 10;
  localparam int unsigned ST_CODE_LSB       = 16;
  localparam int unsigned INT_TRIP          = 0;
  localparam int unsigned INT_OVERRIDE      = 1;
  localparam int unsigned INT_STARTED       = 2;
  localparam int unsigned INT_WIDTH         = 3;
endpackage : dioe_pkg

// ===== src/dioe_func_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dioe_func_if;
  logic force_terminal;
  logic ready_hold;
  logic run_fwd;
  logic estop_level;
  logic trip_reset;
  modport src (output force_terminal, ready_hold, run_fwd, estop_level, trip_reset);
  modport dst (input  force_terminal, ready_hold, run_fwd, estop_level, trip_reset);
endinterface : dioe_func_if
`default_nettype wire

// ===== src/dioe_debounce.sv
`timescale 1ns/1ps
`default_nettype none
module dioe_debounce #(
  parameter int unsigned WIDTH = 5,
  parameter int unsigned COUNT = 1250
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] raw,
  output logic      [WIDTH-1:0] level
);
  localparam int unsigned CW = $clog2(COUNT + 1);
  if (WIDTH < 1 || COUNT < 1)
  begin : g_bad_params
    $error("dioe_debounce: bad parameters");
  end
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] sync;
  logic [CW-1:0]    cnt [WIDTH];
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta <= '0;
      sync <= '0;
    end
    else
    begin
      meta <= raw;
      sync <= meta;
    end
  end
  // a level is taken only after it has held for COUNT cycles
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      level <= '0;
      for (int i = 0; i < WIDTH; i++) cnt[i] <= '0;
    end
    else
    begin
      for (int i = 0; i < WIDTH; i++)
      begin
        if (sync[i] == level[i]) cnt[i] <= '0;
        else if (cnt[i] == CW'(COUNT - 1))
        begin
          cnt[i]   <= '0;
          level[i] <= sync[i];
        end
        else cnt[i] <= cnt[i] + CW'(1);
      end
    end
  end
endmodule : dioe_debounce
`default_nettype wire

// ===== src/dioe_func_map.sv
`timescale 1ns/1ps
`default_nettype none
module dioe_func_map
  import dioe_pkg::*;
(
  input  wire logic [NUM_TERM-1:0]   level,
  input  wire logic [NUM_TERM*8-1:0] selectors,
  input  wire logic                  estop_en,
  dioe_func_if.src                   fn
);
  always_comb
  begin
    fn.force_terminal = 1'b0;
    fn.ready_hold     = 1'b0;
    fn.run_fwd        = 1'b0;
    for (int i = 0; i < NUM_TERM; i++)
    begin
      // terminals 1, 3 and 4 lose their selected function under estop
      if (!(estop_en && (i == 0 || i == 2 || i == 3)))
      begin
        unique case (selectors[i*8 +: 8])
          FUNC_FORCE_TERM: fn.force_terminal = fn.force_terminal | level[i];
          FUNC_READY_HOLD: fn.ready_hold     = fn.ready_hold | level[i];
          FUNC_RUN_FWD:    fn.run_fwd        = fn.run_fwd | level[i];
          default:         ;
        endcase
      end
    end
    // normally-closed stop contact: an open or miswired line reads low
    fn.estop_level = estop_en ? level[2] : 1'b1;
    fn.trip_reset  = estop_en & level[3];
  end
endmodule : dioe_func_map
`default_nettype wire

// ===== testbench/dioe_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module dioe_top_sva
  import dioe_pkg::*;
(
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic [NUM_TERM-1:0] terminal_in,
  input wire logic                estop_enable_switch,
  input wire logic                gate_enable,
  input wire logic                outputs_energized,
  input wire logic                estop_trip
);
  logic [10:0] t3_lo;
  logic [10:0] t3_hi;
  logic [10:0] t4_hi;
  logic [10:0] armed;
  // raw run lengths, saturating, so filter timing can be judged from the pins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      t3_lo <= '0;
      t3_hi <= '0;
      t4_hi <= '0;
      armed <= '0;
    end
    else
    begin
      t3_lo <= terminal_in[2] ? 11'h0 : t3_lo + {10'h0, ~&t3_lo};
      t3_hi <= !terminal_in[2] ? 11'h0 : t3_hi + {10'h0, ~&t3_hi};
      t4_hi <= !terminal_in[3] ? 11'h0 : t4_hi + {10'h0, ~&t4_hi};
      armed <= (terminal_in[2] || !estop_enable_switch) ? 11'h0 : armed + {10'h0, ~&armed};
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_trip_gate; estop_trip |-> !gate_enable; endproperty
  a_trip_gate: assert property (p_trip_gate)
    else $error("gate switching during trip");
  property p_trip_switch; $rose(estop_trip) |-> estop_enable_switch; endproperty
  a_trip_switch: assert property (p_trip_switch)
    else $error("trip without enable switch");
  property p_trip_filter; $rose(estop_trip) |-> t3_lo >= 11'd1250; endproperty
  a_trip_filter: assert property (p_trip_filter)
    else $error("trip before stop contact filtered");
  property p_trip_open; armed >= 11'd1400 |-> estop_trip; endproperty
  a_trip_open: assert property (p_trip_open)
    else $error("open stop loop did not trip");
  property p_trip_clear;
    $fell(estop_trip) && $past(presetn) && estop_enable_switch |-> t4_hi >= 11'd1250;
  endproperty
  a_trip_clear: assert property (p_trip_clear)
    else $error("trip cleared without reset terminal");
  property p_reset_clears;
    estop_enable_switch && t4_hi == 11'd1400 && t3_hi >= 11'd1400 |-> !estop_trip;
  endproperty
  a_reset_clears: assert property (p_reset_clears)
    else $error("reset terminal did not clear trip");
  property p_energized_hold; estop_trip && $past(estop_trip) |-> $stable(outputs_energized); endproperty
  a_energized_hold: assert property (p_energized_hold)
    else $error("energized changed during trip");
  property p_gate_powered; gate_enable |-> outputs_energized; endproperty
  a_gate_powered: assert property (p_gate_powered)
    else $error("switching while stage not energized");
endmodule : dioe_top_sva
bind dioe_top dioe_top_sva u_sva (.pclk(pclk), .presetn(presetn), .terminal_in(terminal_in),
  .estop_enable_switch(estop_enable_switch), .gate_enable(gate_enable),
  .outputs_energized(outputs_energized), .estop_trip(estop_trip));
`default_nettype wire

// ===== testbench/dioe_term_model.sv
`timescale 1ns/1ps
`default_nettype none
module dioe_term_model
  import dioe_pkg::*;
(
  input  wire logic                pclk,
  input  wire logic [NUM_TERM-1:0] want,
  input  wire logic                open_wire,
  output logic      [NUM_TERM-1:0] terminal_in
);
  logic [NUM_TERM-1:0] last;
  logic [NUM_TERM-1:0] moved;
  int                  chatter;
  initial
  begin
    last = '0;
    moved = '0;
    chatter = 0;
    terminal_in = '0;
  end
  // contacts chatter after each change, far shorter than the filter time
  always @(posedge pclk)
  begin
    if (want !== last)
    begin
      moved <= want ^ last;
      last <= want;
      chatter <= 20;
    end
    else if (chatter > 0)
      chatter <= chatter - 1;
    // a broken stop loop reads low, like an opened contact
    terminal_in <= (chatter[1] ? last ^ moved : last) & (open_wire ? 5'h1b : 5'h1f);
  end
endmodule : dioe_term_model
`default_nettype wire

// ===== testbench/drive_input_override_estop_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module drive_input_override_estop_tb_top;
  import dioe_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd_data, seed;
  logic [4:0]  terminal_in, want;
  logic        open_wire, estop_sw, keypad, gate, energized, trip, irq, rd_err;
  logic [1:0]  freq_src, run_src, fs, rs;
  logic [39:0] sel;
  int          n_fail, checks_done;
  dioe_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .terminal_in(terminal_in), .estop_enable_switch(estop_sw),
    .keypad_reset(keypad), .gate_enable(gate), .outputs_energized(energized),
    .estop_trip(trip), .freq_source_select(freq_src), .run_source_select(run_src), .irq(irq));
  dioe_term_model u_term (.pclk(pclk), .want(want), .open_wire(open_wire),
    .terminal_in(terminal_in));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [39:0] one_sel(input int k);
    logic [39:0] s;
    s = {5{FUNC_NONE}};
    s[k*8+:8] = FUNC_FORCE_TERM;
    return s;
  endfunction : one_sel
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // no limit here: only the watchdog ends a hung transfer
    while (pready !== 1'b1)
      @(posedge pclk);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd_data, exp);
  endtask : rd
  // fixed wait: chatter plus sync plus filter count
  task automatic settle(input logic [4:0] v);
    want <= v;
    repeat (1300) @(posedge pclk);
  endtask : settle
  task automatic finish_test();
    if (n_fail == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial
  begin
    repeat (80000) @(posedge pclk);
    n_fail++;
    finish_test();
  end
  initial
  begin
    {presetn, psel, penable, pwrite, open_wire, estop_sw, keypad} = '0;
    {paddr, pwdata, want} = '0;
    {n_fail, checks_done} = '0;
    seed = 32'd93539;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_CTRL, 32'h0);
    rd(ADDR_SEL_LO, SEL_RESET[31:0]);
    rd(ADDR_SEL_HI, {24'h0, SEL_RESET[39:32]});
    rd(8'h40, 32'h0);
    chk({31'h0, rd_err}, 32'h1);
    for (int k = 0; k < NUM_TERM; k++)
    begin
      sel = one_sel(k);
      {rs, fs} = 4'ha | (4'(rnd()) & 4'h5);
      apb(1'b1, ADDR_SEL_LO, sel[31:0]);
      apb(1'b1, ADDR_SEL_HI, {24'h0, sel[39:32]});
      apb(1'b1, ADDR_CTRL, {28'h0, rs, fs});
      settle(5'h1 << k);
      chk({28'h0, run_src, freq_src}, {28'h0, SRC_TERMINALS, SRC_TERMINALS});
      settle(5'h0);
      chk({28'h0, run_src, freq_src}, {28'h0, rs, fs});
    end
    rd(ADDR_INT_STAT, 32'h2);
    apb(1'b1, ADDR_INT_MASK, 32'h0);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, ADDR_INT_MASK, 32'h2);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, ADDR_INT_STAT, 32'h2);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, ADDR_INT_MASK, 32'h7);
    apb(1'b1, ADDR_SEL_LO, SEL_RESET[31:0]);
    apb(1'b1, ADDR_SEL_HI, {24'h0, SEL_RESET[39:32]});
    apb(1'b1, ADDR_CTRL, 32'h10);
    repeat (2400) @(posedge pclk);
    chk({30'h0, energized, gate}, 32'h2);
    repeat (200) @(posedge pclk);
    chk({29'h0, irq, energized, gate}, 32'h7);
    settle(5'h04);
    // sources hold while the motor ramps down, switching goes on meanwhile
    chk({29'h0, freq_src, gate}, 32'h1);
    repeat (2600) @(posedge pclk);
    chk({28'h0, run_src, freq_src}, 32'h5);
    apb(1'b1, ADDR_CTRL, 32'h0);
    settle(5'h08);
    chk({31'h0, gate}, 32'h1);
    apb(1'b1, ADDR_CTRL, 32'h10);
    chk({31'h0, gate}, 32'h1);
    apb(1'b1, ADDR_CTRL, 32'h0);
    // stop loop closed before the switch goes on, else the open loop trips
    settle(5'h04);
    estop_sw <= 1'b1;
    settle(5'h04);
    chk({29'h0, trip, freq_src}, 32'h0);
    open_wire <= 1'b1;
    repeat (1300) @(posedge pclk);
    chk({30'h0, trip, gate}, 32'h2);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk({24'h0, rd_data[23:16]}, {24'h0, ESTOP_TRIP_CODE});
    open_wire <= 1'b0;
    keypad <= 1'b1;
    settle(5'h14);
    keypad <= 1'b0;
    chk({31'h0, trip}, 32'h1);
    settle(5'h0c);
    chk({31'h0, trip}, 32'h0);
    repeat (200) @(posedge pclk);
    settle(5'h04);
    apb(1'b1, ADDR_CTRL, 32'h10);
    repeat (2600) @(posedge pclk);
    settle(5'h00);
    chk({29'h0, energized, gate, trip}, 32'h5);
    apb(1'b1, ADDR_CTRL, 32'h0);
    settle(5'h0c);
    settle(5'h04);
    estop_sw <= 1'b0;
    settle(5'h00);
    chk({31'h0, trip}, 32'h0);
    finish_test();
  end
endmodule : drive_input_override_estop_tb_top
`default_nettype wire
